// file: core/xtl_decode.v
`timescale 1ns/1ps
`include "xtl_defs.vh"

// Behaviour
// - direction load accepts 5..7, copies accumulator
// - direction registers also directly readable and writable
// - immediate XOR result written to accumulator
// - immediate XOR opcode 111010, zero flag, one cycle
// - file XOR; destination bit picks accumulator or file
// - file XOR opcode 000110, updates zero flag and the chosen destination
module xtl_decode (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // Instruction from fetch, one per enabled cycle
    input  wire        instr_valid,
    input  wire [13:0] instr_word,
    // File register read data for the addressed operand
    input  wire [7:0]  file_rd_data,
    // Direct access to the direction registers
    input  wire        dir_wr_en,
    input  wire [1:0]  dir_wr_idx,
    input  wire [7:0]  dir_wr_data,
    input  wire [1:0]  dir_rd_idx,
    output wire [7:0]  dir_rd_data,
    // Accumulator load from the rest of the core
    input  wire        acc_load_en,
    input  wire [7:0]  acc_load_data,
    // File register address and write-back
    output wire [6:0]  file_addr,
    output reg         file_wr_en,
    output reg  [7:0]  file_wr_data,
    // Core state
    output reg  [7:0]  acc_reg,
    output reg         zero_reg,
    output wire [23:0] dir_all,
    output reg         illegal_reg
);
    // ------------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------------
    // Every valid word falls into exactly one class. Unknown opcodes land
    // in the idle class, so the core simply steps past them.
    localparam [4:0] CLS_NONE  = 5'h01;
    localparam [4:0] CLS_XIMM  = 5'h02;
    localparam [4:0] CLS_XFILE = 5'h04;
    localparam [4:0] CLS_DLOAD = 5'h08;
    localparam [4:0] CLS_DREJ  = 5'h10;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function [5:0] opc6;
        input [`XTL_IW-1:0] w;
        begin
            opc6 = w[`XTL_OPC_HI:`XTL_OPC_LO];
        end
    endfunction

    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    // Maps a legal direction select onto its slot in the register bank.
    function [1:0] sel_to_idx;
        input [2:0] sel;
        reg   [2:0] diff;
        begin
            diff       = sel - `XTL_DIR_SEL_MIN;
            sel_to_idx = diff[1:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Operand fields
    // ------------------------------------------------------------------
    wire       hit_dir  = instr_word[`XTL_DIR_OPC_HI:`XTL_DIR_OPC_LO]
                          == `XTL_DIR_OPC;
    wire       hit_ximm = opc6(instr_word) == `XTL_XIMM_OPC;
    wire       hit_xf   = opc6(instr_word) == `XTL_XF_OPC;
    wire [2:0] dir_sel  = instr_word[`XTL_SEL_HI:0];
    wire       dir_ok   = dir_sel >= `XTL_DIR_SEL_MIN &&
                          dir_sel <= `XTL_DIR_SEL_MAX;
    wire       dest_f   = instr_word[`XTL_DEST_BIT];
    wire [7:0] imm_val  = instr_word[`XTL_IMM_HI:0];

    // The file address is driven straight from the word, so the register
    // file answers within the same cycle as the instruction.
    assign file_addr = instr_word[`XTL_FA_HI:0];

    // ------------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------------
    reg  [4:0] instr_cls;

    always @* begin
        instr_cls = CLS_NONE;
        if (instr_valid) begin
            if (hit_ximm) begin
                instr_cls = CLS_XIMM;
            end else if (hit_xf) begin
                instr_cls = CLS_XFILE;
            end else if (hit_dir && dir_ok) begin
                instr_cls = CLS_DLOAD;
            end else if (hit_dir) begin
                instr_cls = CLS_DREJ;
            end
        end
    end

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    wire [7:0] x_imm  = acc_reg ^ imm_val;
    wire [7:0] x_file = acc_reg ^ file_rd_data;

    // ------------------------------------------------------------------
    // Direction register bank
    // ------------------------------------------------------------------
    // The instruction load wins over a direct write in the same cycle,
    // so a program sees its own store take effect. The direct write is
    // lost in that case; software should not mix the two paths.
    wire       dload  = (instr_cls == CLS_DLOAD);
    wire       bwr_en = dload || dir_wr_en;
    wire [1:0] bwr_ix = dload ? sel_to_idx(dir_sel) : dir_wr_idx;
    wire [7:0] bwr_d  = dload ? acc_reg : dir_wr_data;

    xtl_dir_bank #(
        .NUM (3)
    ) u_bank (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (bwr_en),
        .wr_idx  (bwr_ix),
        .wr_data (bwr_d),
        .rd_idx  (dir_rd_idx),
        .rd_data (dir_rd_data),
        .dir_all (dir_all)
    );

    // ------------------------------------------------------------------
    // Next state, one cycle per instruction
    // ------------------------------------------------------------------
    reg  [7:0] acc_next;
    reg        zero_next;
    reg        file_wr_en_next;
    reg  [7:0] file_wr_data_next;
    reg        illegal_next;

    // An external accumulator load only takes effect when no exclusive-OR
    // writes the accumulator in the same cycle; that result has priority.
    always @* begin
        acc_next          = acc_load_en ? acc_load_data : acc_reg;
        zero_next         = zero_reg;
        file_wr_en_next   = 1'b0;
        file_wr_data_next = file_wr_data;
        illegal_next      = 1'b0;
        case (instr_cls)
            CLS_XIMM: begin
                acc_next  = x_imm;
                zero_next = is_zero(x_imm);
            end
            CLS_XFILE: begin
                zero_next = is_zero(x_file);
                if (dest_f) begin
                    // Write-back is registered and trails by one cycle.
                    file_wr_en_next   = 1'b1;
                    file_wr_data_next = x_file;
                end else begin
                    acc_next = x_file;
                end
            end
            CLS_DLOAD: begin
                // Zero flag holds; only the direction bank changes.
                zero_next = zero_reg;
            end
            CLS_DREJ: begin
                // A refused select leaves every direction register alone.
                illegal_next = 1'b1;
            end
            default: begin
                illegal_next = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Accumulator and zero flag
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            acc_reg  <= `XTL_ACC_RST;
            zero_reg <= `XTL_ZERO_RST;
        end else begin
            acc_reg  <= acc_next;
            zero_reg <= zero_next;
        end
    end

    // ------------------------------------------------------------------
    // File write-back
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            file_wr_en   <= 1'b0;
            file_wr_data <= 8'h00;
        end else begin
            file_wr_en   <= file_wr_en_next;
            file_wr_data <= file_wr_data_next;
        end
    end

    // ------------------------------------------------------------------
    // Refusal flag
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            illegal_reg <= 1'b0;
        end else begin
            illegal_reg <= illegal_next;
        end
    end
endmodule // xtl_decode

// file: core/xtl_dir_bank.v
`timescale 1ns/1ps
`include "xtl_defs.vh"

// Three port direction registers, loaded by the direction-load instruction
// or by a direct register write; read data come from a register.
module xtl_dir_bank #(
    parameter NUM = 3
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             reset,
    // Write side
    input  wire             wr_en,
    input  wire [1:0]       wr_idx,
    input  wire [7:0]       wr_data,
    // Read side
    input  wire [1:0]       rd_idx,
    output reg  [7:0]       rd_data,
    // Flat view of all registers
    output wire [8*NUM-1:0] dir_all
);
    reg [7:0] dir_reg [0:NUM-1];

    genvar g;
    generate
        for (g = 0; g < NUM; g = g + 1) begin : g_dir
            always @(posedge ref_clk) begin
                if (reset) begin
                    dir_reg[g] <= `XTL_DIR_RST;
                end else if (wr_en && wr_idx == g) begin
                    dir_reg[g] <= wr_data;
                end
            end
            assign dir_all[8*g+7:8*g] = dir_reg[g];
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= `XTL_DIR_RST;
        end else if (rd_idx < NUM) begin
            rd_data <= dir_reg[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule // xtl_dir_bank

// file: inc/xtl_defs.vh
`ifndef XTL_DEFS_VH
`define XTL_DEFS_VH

// ----------------------------------------------------------------------
// Instruction encodings (14-bit words)
// ----------------------------------------------------------------------
`define XTL_IW            14
`define XTL_DIR_OPC       11'h00c
`define XTL_DIR_OPC_HI    13
`define XTL_DIR_OPC_LO    3
`define XTL_DIR_SEL_MIN   3'h5
`define XTL_DIR_SEL_MAX   3'h7
`define XTL_XIMM_OPC      6'h3a
`define XTL_XF_OPC        6'h06
`define XTL_OPC_HI        13
`define XTL_OPC_LO        8
`define XTL_DEST_BIT      7
`define XTL_SEL_HI        2
`define XTL_FA_HI         6
`define XTL_IMM_HI        7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define XTL_ACC_RST       8'h00
`define XTL_DIR_RST       8'hff
`define XTL_ZERO_RST      1'b0
`define XTL_CYCLES        1

`endif

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
    reg         ref_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
    reg         acc_load_en = 1'b0, dir_wr_en = 1'b0;
    reg  [13:0] instr_word = 14'h0000;
    reg  [7:0]  acc_load_data = 8'h00, dir_wr_data = 8'h00;
    reg  [1:0]  dir_wr_idx = 2'h1, dir_rd_idx = 2'h1;
    wire [7:0]  file_rd_data, file_wr_data, acc_reg, dir_rd_data;
    wire [6:0]  file_addr;
    wire        file_wr_en, zero_reg, illegal_reg;
    wire [23:0] dir_all;
    integer     mismatches = 0, compares = 0, k;
    reg  [30:0] rows [0:4] = '{{8'hb5, 14'h3aaf, 8'h1a, 1'b0},
        {8'h55, 14'h3a55, 8'h00, 1'b1}, {8'h00, 14'h3aff, 8'hff, 1'b0},
        {8'h0f, 14'h0610, 8'h23, 1'b0}, {8'h43, 14'h067f, 8'h00, 1'b1}};
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
    xtl_decode i_xtl_decode (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .instr_valid   (instr_valid),
        .instr_word    (instr_word),
        .file_rd_data  (file_rd_data),
        .dir_wr_en     (dir_wr_en),
        .dir_wr_idx    (dir_wr_idx),
        .dir_wr_data   (dir_wr_data),
        .dir_rd_idx    (dir_rd_idx),
        .dir_rd_data   (dir_rd_data),
        .acc_load_en   (acc_load_en),
        .acc_load_data (acc_load_data),
        .file_addr     (file_addr),
        .file_wr_en    (file_wr_en),
        .file_wr_data  (file_wr_data),
        .acc_reg       (acc_reg),
        .zero_reg      (zero_reg),
        .dir_all       (dir_all),
        .illegal_reg   (illegal_reg)
    );
    xtl_file_model i_xtl_file_model (
        .ref_clk      (ref_clk),
        .file_addr    (file_addr),
        .file_wr_en   (file_wr_en),
        .file_wr_data (file_wr_data),
        .file_rd_data (file_rd_data)
    );
    initial forever #25 ref_clk = ~ref_clk;
    task run(input [7:0] a, input [13:0] w); begin
        @(posedge ref_clk) #1 acc_load_en = 1'b1;
        acc_load_data = a;
        @(posedge ref_clk) #1 acc_load_en = 1'b0;
        instr_valid = 1'b1;
        instr_word = w;
        @(posedge ref_clk) #1 instr_valid = 1'b0;
    end endtask
    task summarize; begin
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    end endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 reset = 1'b0;
        `CHK("acc", 8'h00, acc_reg)
        `CHK("zero", 1'b0, zero_reg)
        `CHK("dir", 24'hffffff, dir_all)
        `CHK("dir_rd", 8'hff, dir_rd_data)
        for (k = 0; k < 5; k++) begin
            run(rows[k][30:23], rows[k][22:9]);
            `CHK("acc", rows[k][8:1], acc_reg)
            `CHK("zero", rows[k][0], zero_reg)
        end
        run(8'h0f, 14'h0690);
        `CHK("wr_data", 8'h23, file_wr_data)
        `CHK("wr_en", 1'b1, file_wr_en)
        `CHK("addr", 7'h10, file_addr)
        `CHK("acc", 8'h0f, acc_reg)
        run(8'h23, 14'h0610);
        `CHK("back", 8'h00, acc_reg)
        for (k = 5; k < 8; k++) begin
            run(8'h10 + k[7:0], {11'h00c, k[2:0]});
            `CHK("dir", 8'h10 + k[7:0], dir_all[8*(k-5) +: 8])
            `CHK("zero", 1'b1, zero_reg)
        end
        for (k = 0; k < 5; k++) begin
            run(8'haa, {11'h00c, k[2:0]});
            `CHK("illegal", 1'b1, illegal_reg)
            `CHK("dir", 24'h171615, dir_all)
        end
        @(posedge ref_clk) #1 dir_wr_en = 1'b1;
        dir_wr_data = 8'hc3;
        @(posedge ref_clk) #1 dir_wr_en = 1'b0;
        @(posedge ref_clk) #1 `CHK("dir_rd", 8'hc3, dir_rd_data)
        dir_rd_idx = 2'h3;
        @(posedge ref_clk) #1 `CHK("dir_rd", 8'h00, dir_rd_data)
        summarize;
    end
endmodule // tb
bind xtl_decode xtl_decode_monitor i_xtl_decode_monitor (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .instr_valid  (instr_valid),
    .instr_word   (instr_word),
    .file_rd_data (file_rd_data),
    .dir_wr_en    (dir_wr_en),
    .acc_reg      (acc_reg),
    .zero_reg     (zero_reg),
    .file_wr_en   (file_wr_en),
    .file_wr_data (file_wr_data),
    .dir_all      (dir_all),
    .illegal_reg  (illegal_reg)
);

// file: verif/xtl_decode_monitor.sv
`timescale 1ns/1ps
module xtl_decode_monitor (
    // Watched ports
    input wire        ref_clk,
    input wire        reset,
    input wire        instr_valid,
    input wire [13:0] instr_word,
    input wire [7:0]  file_rd_data,
    input wire        dir_wr_en,
    input wire [7:0]  acc_reg,
    input wire        zero_reg,
    input wire        file_wr_en,
    input wire [7:0]  file_wr_data,
    input wire [23:0] dir_all,
    input wire        illegal_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire       imm = instr_valid && instr_word[13:8] == 6'h3a;
    wire       xf  = instr_valid && instr_word[13:8] == 6'h06;
    wire       wb  = xf && instr_word[7];
    wire       dl  = instr_valid && instr_word[13:3] == 11'h00c;
    wire       dv  = dl && instr_word[2:0] >= 3'h5;
    wire [7:0] rf  = acc_reg ^ file_rd_data;
    chk_imm_acc: assert property (imm |=>
        acc_reg == $past(acc_reg ^ instr_word[7:0]))
        else $error("immediate result wrong");
    chk_imm_zero: assert property (imm |=> zero_reg == ~|acc_reg)
        else $error("immediate zero flag wrong");
    chk_xf_acc: assert property (xf && !instr_word[7] |=>
        acc_reg == $past(rf)) else $error("file xor result wrong");
    chk_xf_back: assert property (wb |=>
        file_wr_en && file_wr_data == $past(rf))
        else $error("write-back wrong");
    chk_wb_only: assert property (!wb |=> !file_wr_en)
        else $error("stray write-back");
    chk_xf_zero: assert property (xf |=> zero_reg == ~|$past(rf))
        else $error("file xor zero flag wrong");
    chk_dir_load: assert property (dv |=>
        $stable(zero_reg) &&
        dir_all[8*($past(instr_word[2:0])-5) +: 8] == $past(acc_reg))
        else $error("direction load wrong");
    chk_dir_refuse: assert property (dl && !dv && !dir_wr_en |=>
        illegal_reg && $stable(dir_all) && $stable(zero_reg))
        else $error("refusal wrong");
endmodule // xtl_decode_monitor

// file: verif/xtl_file_model.sv
`timescale 1ns/1ps
module xtl_file_model (
    // Register file port
    input  wire       ref_clk,
    input  wire [6:0] file_addr,
    input  wire       file_wr_en,
    input  wire [7:0] file_wr_data,
    output wire [7:0] file_rd_data
);
    // Write-back trails the instruction by a cycle, so its address is held.
    reg [7:0] mem_reg [0:127];
    reg [6:0] addr_reg;
    integer   i;
    initial for (i = 0; i < 128; i++) mem_reg[i] = i[7:0] ^ 8'h3c;
    assign file_rd_data = mem_reg[file_addr];
    always @(posedge ref_clk) begin
        addr_reg <= file_addr;
        if (file_wr_en) mem_reg[addr_reg] <= file_wr_data;
    end
endmodule // xtl_file_model
